/* File: hdl/spi_guard_pkg.sv */
// Constants shared by both ends of the serial memory link.
// Notes on behaviour
// - Pause low suspends transfer; resumes where left.
// - Host keeps clock low around pause edges.
// - Device starts idle in standby after power.
// - First select falling edge needed before commands.
// - Data output floats at power-up.
// - Write-enable latch cleared at power-up.
// - Only set-write-enable command sets the latch.
// - Write starts only on correctly timed release.
// - Self-timed write ends within 10 ms.
// - Host waits 1 ms read, 5 ms write.
// - Select must rise right after enable command.
// - Write completes only on byte-boundary release.
// - Status shows write in progress while writing.
package spi_guard_pkg;
   localparam int CLK_HZ = 25000000;
   localparam int NV_WRITE_DURATION_MS = 10;
   localparam int NV_WRITE_DURATION_FAST_MS = 5;
   localparam int POWERUP_TO_READ_DELAY_MS = 1;
   localparam int POWERUP_TO_WRITE_DELAY_MS = 5;
   localparam int NV_WRITE_CYCLES = (CLK_HZ / 1000) * NV_WRITE_DURATION_FAST_MS;
   localparam int PU_READ_CYCLES = (CLK_HZ / 1000) * POWERUP_TO_READ_DELAY_MS;
   localparam int PU_WRITE_CYCLES = (CLK_HZ / 1000) * POWERUP_TO_WRITE_DELAY_MS;
   localparam int SCK_HALF_CYCLES = 13;
   localparam logic [7:0] OP_WRSR = 8'h01;
   localparam logic [7:0] OP_WRITE = 8'h02;
   localparam logic [7:0] OP_READ = 8'h03;
   localparam logic [7:0] OP_WRDI = 8'h04;
   localparam logic [7:0] OP_RDSR = 8'h05;
   localparam logic [7:0] OP_SET_WE = 8'h06;
   localparam int INPROG_BIT = 0;
   localparam int LATCH_BIT = 1;
endpackage

/* File: hdl/spi_guard_if.sv */
// Interface joining the host and the memory device.
`timescale 1ns/1ps
interface spi_guard_if;
   logic cs_n;
   logic sck;
   logic sdi;
   logic pause_n;
   logic sdo;
   logic sdo_oe;
   modport host (output cs_n, output sck, output sdi, output pause_n, input sdo, input sdo_oe);
   modport dev (input cs_n, input sck, input sdi, input pause_n, output sdo, output sdo_oe);
endinterface

/* File: hdl/eeprom_guard_dev.sv */
// Memory device end: pause, power-up state and write guards.
`timescale 1ns/1ps
module eeprom_guard_dev #(
   parameter int WRITE_CYCLES = spi_guard_pkg::NV_WRITE_CYCLES
) (
   // Clock and reset.
   input wire logic mclk,
   input wire logic srst,
   // Link.
   spi_guard_if.dev link,
   // Status to the user.
   output logic write_in_progress_flag,
   output logic write_enable_latch,
   output logic armed,
   output logic nv_write_start
);
   if (WRITE_CYCLES < 1) begin : g_bad_cycles
      $error("WRITE_CYCLES must be at least one");
   end
   typedef enum {ST_IDLE, ST_OP, ST_ADDR, ST_DATA, ST_STAT, ST_OUT} dst_e;
   function automatic dst_e op_next(input logic [7:0] op);
      if (op == spi_guard_pkg::OP_WRITE || op == spi_guard_pkg::OP_READ) begin
         return ST_ADDR;
      end else if (op == spi_guard_pkg::OP_WRSR) begin
         return ST_DATA;
      end else if (op == spi_guard_pkg::OP_RDSR) begin
         return ST_STAT;
      end else begin
         return ST_OUT;
      end
   endfunction
   function automatic logic bit_wrap(input dst_e st, input logic [4:0] cnt);
      if (st == ST_ADDR) begin
         return cnt == 5'h0F;
      end else if (st == ST_OUT) begin
         return 1'b0;
      end else begin
         return cnt == 5'h07;
      end
   endfunction
   function automatic logic [7:0] status_word(input logic latch, input logic busy);
      logic [7:0] w;
      w = 8'h00;
      w[spi_guard_pkg::INPROG_BIT] = busy;
      w[spi_guard_pkg::LATCH_BIT] = latch;
      return w;
   endfunction
   dst_e st_r;
   logic sck_q_r;
   logic cs_q_r;
   logic [7:0] sh_r;
   logic [4:0] cnt_r;
   logic [7:0] op_r;
   logic byte_done_r;
   logic [31:0] wcnt_r;
   logic [7:0] out_r;
   logic sdo_r;
   logic sdo_oe_r;
   logic active;
   logic rise;
   logic fall;
   logic cs_fall;
   logic cs_rise;
   logic out_live_r;
   logic [7:0] rx_word;
   logic take_bit;
   dst_e st_nxt;
   assign active = link.pause_n & ~link.cs_n;
   assign rise = active & link.sck & ~sck_q_r;
   assign fall = active & ~link.sck & sck_q_r;
   assign cs_fall = cs_q_r & ~link.cs_n;
   assign cs_rise = ~cs_q_r & link.cs_n;
   assign rx_word = {sh_r[6:0], link.sdi};
   assign take_bit = rise && st_r != ST_IDLE && !cs_fall;
   assign link.sdo = sdo_r;
   assign link.sdo_oe = sdo_oe_r;
   always_ff @(posedge mclk) begin
      if (srst) begin
         sck_q_r <= 1'b0;
         cs_q_r <= 1'b1;
      end else begin
         if (link.pause_n) begin
            sck_q_r <= link.sck;
         end
         cs_q_r <= link.cs_n;
      end
   end
   always_ff @(posedge mclk) begin
      if (srst) begin
         armed <= 1'b0;
      end else if (cs_fall) begin
         armed <= 1'b1;
      end
   end
   always_comb begin
      st_nxt = st_r;
      case (st_r)
         ST_OP: begin
            if (cnt_r == 5'h07) begin
               st_nxt = op_next(rx_word);
            end
         end
         ST_ADDR: begin
            if (cnt_r == 5'h0F) begin
               st_nxt = ST_DATA;
            end
         end
         default: st_nxt = st_r;
      endcase
   end
   always_ff @(posedge mclk) begin
      if (srst) begin
         st_r <= ST_IDLE;
      end else if (link.cs_n) begin
         st_r <= ST_IDLE;
      end else if (cs_fall) begin
         st_r <= armed ? ST_OP : ST_IDLE;
      end else if (take_bit) begin
         st_r <= st_nxt;
      end
   end
   always_ff @(posedge mclk) begin
      if (srst) begin
         cnt_r <= 5'h00;
      end else if (link.cs_n || cs_fall) begin
         cnt_r <= 5'h00;
      end else if (take_bit) begin
         if (bit_wrap(st_r, cnt_r)) begin
            cnt_r <= 5'h00;
         end else begin
            cnt_r <= cnt_r + 5'h01;
         end
      end
   end
   // A byte counts as data only once the header is over, so a release right after the address starts nothing.
   always_ff @(posedge mclk) begin
      if (srst) begin
         byte_done_r <= 1'b0;
      end else if (link.cs_n || cs_fall) begin
         byte_done_r <= 1'b0;
      end else if (take_bit) begin
         byte_done_r <= (cnt_r[2:0] == 3'h7) && (st_r == ST_DATA || st_nxt != ST_DATA);
      end
   end
   always_ff @(posedge mclk) begin
      if (srst) begin
         sh_r <= 8'h00;
      end else if (take_bit) begin
         sh_r <= rx_word;
      end
   end
   always_ff @(posedge mclk) begin
      if (srst) begin
         op_r <= 8'h00;
      end else if (take_bit && st_r == ST_OP && cnt_r == 5'h07) begin
         op_r <= rx_word;
      end else if (take_bit && st_r == ST_OUT) begin
         op_r <= 8'h00;
      end
   end
   always_ff @(posedge mclk) begin
      if (srst) begin
         write_enable_latch <= 1'b0;
      end else if (cs_rise && st_r == ST_OUT && byte_done_r && cnt_r == 5'h00
                   && op_r == spi_guard_pkg::OP_SET_WE && !write_in_progress_flag) begin
         write_enable_latch <= 1'b1;
      end else if (cs_rise && st_r == ST_OUT && op_r == spi_guard_pkg::OP_WRDI && !write_in_progress_flag) begin
         write_enable_latch <= 1'b0;
      end else if (nv_write_start) begin
         write_enable_latch <= 1'b0;
      end
   end
   always_ff @(posedge mclk) begin
      if (srst) begin
         nv_write_start <= 1'b0;
      end else begin
         nv_write_start <= cs_rise && st_r == ST_DATA && byte_done_r && cnt_r == 5'h00
                           && (op_r == spi_guard_pkg::OP_WRITE || op_r == spi_guard_pkg::OP_WRSR)
                           && write_enable_latch && !write_in_progress_flag;
      end
   end
   always_ff @(posedge mclk) begin
      if (srst) begin
         write_in_progress_flag <= 1'b0;
         wcnt_r <= 32'h0000_0000;
      end else if (nv_write_start) begin
         write_in_progress_flag <= 1'b1;
         wcnt_r <= 32'(WRITE_CYCLES - 1);
      end else if (wcnt_r != 32'h0000_0000) begin
         wcnt_r <= wcnt_r - 32'h0000_0001;
      end else begin
         write_in_progress_flag <= 1'b0;
      end
   end
   // The output keeps its bit through a pause and drives it again on release.
   always_ff @(posedge mclk) begin
      if (srst) begin
         out_r <= 8'h00;
         sdo_r <= 1'b0;
         sdo_oe_r <= 1'b0;
         out_live_r <= 1'b0;
      end else if (link.cs_n || st_r != ST_STAT) begin
         sdo_oe_r <= 1'b0;
         out_live_r <= 1'b0;
      end else if (!link.pause_n) begin
         sdo_oe_r <= 1'b0;
      end else if (fall) begin
         if (cnt_r == 5'h00) begin
            out_r <= status_word(write_enable_latch, write_in_progress_flag) << 1;
            sdo_r <= 1'b0;
         end else begin
            sdo_r <= out_r[7];
            out_r <= {out_r[6:0], 1'b0};
         end
         sdo_oe_r <= 1'b1;
         out_live_r <= 1'b1;
      end else begin
         sdo_oe_r <= out_live_r;
      end
   end
endmodule

/* File: hdl/eeprom_guard_host.sv */
// Host end: issues guarded commands and paces pause and power-up.
`timescale 1ns/1ps
module eeprom_guard_host #(
   parameter int READ_WAIT = spi_guard_pkg::PU_READ_CYCLES,
   parameter int WRITE_WAIT = spi_guard_pkg::PU_WRITE_CYCLES
) (
   // Clock and reset.
   input wire logic mclk,
   input wire logic srst,
   // Link.
   spi_guard_if.host link,
   // User command: bytes to send, count, start.
   input wire logic start,
   input wire logic [31:0] tx_bytes,
   input wire logic [2:0] n_bytes,
   input wire logic is_write,
   input wire logic pause_req,
   // User answers.
   output logic busy,
   output logic done,
   output logic [7:0] rx_byte,
   output logic read_ok,
   output logic write_ok
);
   if (READ_WAIT < 1 || WRITE_WAIT < READ_WAIT) begin : g_bad_waits
      $error("Power-up waits out of range");
   end
   typedef enum {H_PWR, H_IDLE, H_RUN, H_END} hst_e;
   hst_e st_r;
   logic [31:0] pu_r;
   logic [4:0] div_r;
   logic [5:0] bit_r;
   logic [5:0] nbits_r;
   logic [31:0] sh_r;
   logic paused_r;
   always_ff @(posedge mclk) begin
      if (srst) begin
         pu_r <= 32'h0000_0000;
         read_ok <= 1'b0;
         write_ok <= 1'b0;
      end else begin
         if (pu_r != 32'hFFFF_FFFF) begin
            pu_r <= pu_r + 32'h0000_0001;
         end
         read_ok <= (pu_r >= 32'(READ_WAIT));
         write_ok <= (pu_r >= 32'(WRITE_WAIT));
      end
   end
   always_ff @(posedge mclk) begin
      if (srst) begin
         st_r <= H_PWR;
         link.cs_n <= 1'b1;
         link.sck <= 1'b0;
         link.sdi <= 1'b0;
         link.pause_n <= 1'b1;
         div_r <= 5'h00;
         bit_r <= 6'h00;
         nbits_r <= 6'h00;
         sh_r <= 32'h0000_0000;
         paused_r <= 1'b0;
         busy <= 1'b1;
         done <= 1'b0;
         rx_byte <= 8'h00;
      end else begin
         done <= 1'b0;
         case (st_r)
            H_PWR: begin
               if (read_ok) begin
                  st_r <= H_IDLE;
                  busy <= 1'b0;
               end
            end
            H_IDLE: begin
               if (start && (is_write ? write_ok : read_ok) && n_bytes != 3'h0) begin
                  link.cs_n <= 1'b0;
                  sh_r <= tx_bytes;
                  link.sdi <= tx_bytes[31];
                  nbits_r <= {n_bytes, 3'h0};
                  bit_r <= 6'h00;
                  div_r <= 5'h00;
                  busy <= 1'b1;
                  st_r <= H_RUN;
               end
            end
            H_RUN: begin
               if (!link.sck && pause_req != paused_r) begin
                  paused_r <= pause_req;
                  link.pause_n <= ~pause_req;
               end else if (paused_r) begin
                  div_r <= 5'h00;
               end else if (div_r != 5'(spi_guard_pkg::SCK_HALF_CYCLES - 1)) begin
                  div_r <= div_r + 5'h01;
               end else begin
                  div_r <= 5'h00;
                  if (!link.sck) begin
                     link.sck <= 1'b1;
                     rx_byte <= {rx_byte[6:0], link.sdo_oe & link.sdo};
                  end else begin
                     link.sck <= 1'b0;
                     bit_r <= bit_r + 6'h01;
                     sh_r <= {sh_r[30:0], 1'b0};
                     link.sdi <= sh_r[30];
                     if (bit_r + 6'h01 == nbits_r) begin
                        st_r <= H_END;
                     end
                  end
               end
            end
            H_END: begin
               if (div_r != 5'(spi_guard_pkg::SCK_HALF_CYCLES - 1)) begin
                  div_r <= div_r + 5'h01;
               end else begin
                  link.cs_n <= 1'b1;
                  busy <= 1'b0;
                  done <= 1'b1;
                  st_r <= H_IDLE;
               end
            end
            default: st_r <= H_IDLE;
         endcase
      end
   end
endmodule

/* File: verification/serial_guard_props.sv */
// Checker for the link between host and memory device.
`timescale 1ns/1ps
module serial_guard_props #(
   parameter int WRITE_CYCLES = 20
) (
   // Clock and reset.
   input logic mclk,
   input logic srst,
   // Link.
   input logic cs_n,
   input logic sck,
   input logic pause_n,
   input logic sdo_oe,
   // Device status.
   input logic write_in_progress_flag,
   input logic write_enable_latch,
   input logic armed,
   input logic nv_write_start
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (srst);
   logic [31:0] prog_cnt_r;
   always_ff @(posedge mclk) begin
      if (srst || !write_in_progress_flag) begin
         prog_cnt_r <= 32'h0;
      end else begin
         prog_cnt_r <= prog_cnt_r + 32'h1;
      end
   end
   // The enable is a flop, so it floats one clock after the pause is seen.
   AST_PAUSE_FLOAT: assert property (!pause_n && !$past(pause_n) |-> !sdo_oe)
      else $error("data out driven while paused");
   AST_PAUSE_EDGE: assert property ($changed(pause_n) |-> !sck)
      else $error("pause changed with clock high");
   AST_PAUSE_FREEZE: assert property (!pause_n && !$past(pause_n) |-> $stable(sck))
      else $error("clock moved while paused");
   AST_RESET_STATE: assert property ($past(srst) |-> !write_enable_latch && !write_in_progress_flag
      && !armed && !sdo_oe) else $error("device not idle after reset");
   AST_UNARMED_IDLE: assert property (!armed |-> !write_enable_latch && !nv_write_start)
      else $error("command taken before first select");
   AST_START_ON_RISE: assert property (nv_write_start |-> $past(cs_n) && (!$past(cs_n, 2) || !$past(cs_n, 3)))
      else $error("write start not at select release");
   AST_START_NEEDS_LATCH: assert property (nv_write_start |-> $past(write_enable_latch)
      && !$past(write_in_progress_flag)) else $error("write started without latch");
   AST_PROG_FOLLOWS: assert property (nv_write_start |=> write_in_progress_flag)
      else $error("busy flag missing after write start");
   AST_PROG_LENGTH: assert property ($fell(write_in_progress_flag) |-> prog_cnt_r == WRITE_CYCLES)
      else $error("write duration wrong");
   AST_LATCH_ON_RELEASE: assert property ($rose(write_enable_latch) |-> cs_n)
      else $error("latch set while selected");
   cover property (nv_write_start);
   cover property ($fell(pause_n));
   cover property ($fell(write_in_progress_flag));
endmodule

/* File: verification/tb.sv */
// Self-checking bench joining host and device ends.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
   $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
module tb;
   localparam int WC = 1000;
   localparam logic [7:0] SWE = spi_guard_pkg::OP_SET_WE;
   localparam logic [7:0] WD = spi_guard_pkg::OP_WRDI;
   localparam logic [7:0] WR = spi_guard_pkg::OP_WRITE;
   localparam logic [7:0] WS = spi_guard_pkg::OP_WRSR;
   localparam logic [7:0] RS = spi_guard_pkg::OP_RDSR;
   localparam logic [7:0] RD = spi_guard_pkg::OP_READ;
   logic [7:0] ops [14] = '{SWE, SWE, WR, WR, RS, SWE, WR, SWE, WS, RS, SWE, WD, RS, RD};
   int lens [14] = '{1, 1, 3, 4, 2, 2, 4, 1, 2, 2, 1, 1, 2, 4};
   logic mclk = 1'b0;
   logic srst = 1'b1;
   logic start = 1'b0;
   logic [31:0] tx_bytes = 32'h0;
   logic [2:0] n_bytes = 3'h1;
   logic is_write = 1'b0;
   logic pause_req = 1'b0;
   logic pause_en = 1'b0;
   logic busy, done, read_ok, write_ok, in_prog, wel, armed, nv_start;
   logic [7:0] rx_byte;
   int miscompares = 0;
   int n_compared = 0;
   int starts = 0;
   int exp_starts = 0;
   logic exp_wel = 1'b0;
   logic exp_prog = 1'b0;
   logic [1:0] stat_q[$];
   always #20 mclk = ~mclk;
   always @(posedge mclk) begin
      if (nv_start) starts++;
      if (!pause_en) pause_req <= 1'b0;
      else if ($urandom_range(0, 15) == 0) pause_req <= ~pause_req;
   end
   spi_guard_if spi_guard_if_i ();
   eeprom_guard_host #(.READ_WAIT(10), .WRITE_WAIT(20)) eeprom_guard_host_i (.mclk(mclk), .srst(srst),
      .link(spi_guard_if_i), .start(start), .tx_bytes(tx_bytes), .n_bytes(n_bytes), .is_write(is_write),
      .pause_req(pause_req), .busy(busy), .done(done), .rx_byte(rx_byte), .read_ok(read_ok), .write_ok(write_ok));
   eeprom_guard_dev #(.WRITE_CYCLES(WC)) eeprom_guard_dev_i (.mclk(mclk), .srst(srst), .link(spi_guard_if_i),
      .write_in_progress_flag(in_prog), .write_enable_latch(wel), .armed(armed), .nv_write_start(nv_start));
   serial_guard_props #(.WRITE_CYCLES(WC)) serial_guard_props_i (.mclk(mclk), .srst(srst),
      .cs_n(spi_guard_if_i.cs_n), .sck(spi_guard_if_i.sck), .pause_n(spi_guard_if_i.pause_n),
      .sdo_oe(spi_guard_if_i.sdo_oe), .write_in_progress_flag(in_prog), .write_enable_latch(wel), .armed(armed),
      .nv_write_start(nv_start));
   task automatic test_done();
      if (miscompares == 0 && n_compared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic wait_until(ref logic s, input logic v, input int lim);
      for (int i = 0; i < lim && s !== v; i++) @(negedge mclk);
      if (s !== v) begin
         miscompares++;
         test_done();
      end
   endtask
   task automatic send(input int k);
      logic [7:0] op;
      logic [1:0] exp_stat;
      op = ops[k];
      @(posedge mclk);
      tx_bytes <= {op, 24'($urandom)};
      n_bytes <= 3'(lens[k]);
      is_write <= (op == WR || op == WS);
      start <= 1'b1;
      @(posedge mclk);
      start <= 1'b0;
      wait_until(done, 1'b1, 9000);
      repeat (4) @(negedge mclk);
      if (op == SWE && lens[k] == 1) exp_wel = 1'b1;
      else if (op == WD) exp_wel = 1'b0;
      else if (exp_wel && (op == WR && lens[k] >= 4 || op == WS && lens[k] >= 2)) begin
         exp_starts++;
         exp_wel = 1'b0;
         exp_prog = 1'b1;
      end
      if (op == RS) begin
         stat_q.push_back({exp_wel, exp_prog});
         exp_stat = stat_q.pop_front();
         `CHK("status", exp_stat, rx_byte[1:0])
         wait_until(in_prog, 1'b0, 2000);
         exp_prog = 1'b0;
      end
      `CHK("latch", exp_wel, wel)
      `CHK("starts", exp_starts, starts)
      `CHK("armed", 1'b1, armed)
   endtask
   initial begin
      void'($urandom(32'h4728AC0C));
      repeat (8) @(posedge mclk);
      srst <= 1'b0;
      @(negedge mclk);
      `CHK("latch", 1'b0, wel)
      `CHK("in_prog", 1'b0, in_prog)
      `CHK("sdo_oe", 1'b0, spi_guard_if_i.sdo_oe)
      wait_until(write_ok, 1'b1, 200);
      wait_until(busy, 1'b0, 200);
      `CHK("read_ok", 1'b1, read_ok)
      @(posedge mclk);
      tx_bytes <= {SWE, 24'h0};
      start <= 1'b1;
      @(posedge mclk);
      start <= 1'b0;
      wait_until(done, 1'b1, 9000);
      repeat (4) @(negedge mclk);
      `CHK("latch", 1'b0, wel)
      for (int p = 0; p < 2; p++) begin
         pause_en = p[0];
         for (int k = 1; k < 14; k++) send(k);
      end
      pause_en = 1'b0;
      test_done();
   end
endmodule
